// >>> design/std_event_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "ses_map.svh"
module std_event_status
  import ses_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // event inputs, one-cycle pulses from the command engine
  input  wire logic         cmd_syntax_err_i,
  input  wire logic         cmd_semantic_err_i,
  input  wire logic         trig_in_msg_i,
  input  wire logic         data_range_err_i,
  input  wire logic         exec_fail_i,
  input  wire logic         dev_err_i,
  input  wire logic         query_empty_i,
  input  wire logic         query_lost_i,
  input  wire logic         req_ctrl_i,
  input  wire logic         opc_armed_i,
  input  wire logic         ops_done_i,
  // common commands
  input  wire logic         esr_query_i,
  input  wire logic         cls_i,
  input  wire logic         ese_wr_i,
  input  wire logic [7:0]   ese_data_i,
  // answers
  output logic              resp_valid_o,
  output logic [`SES_W-1:0] resp_data_o,
  output logic [7:0]        ese_mask_o,
  output logic              summary_o
);
  // ****************************************
  // event collection
  // ****************************************
  evt_t evt_set;
  evt_t evt_q;
  logic clr;

  always_comb begin
    evt_set                 = `SES_ZERO_EVT;
    evt_set[`SES_BIT_CME]   = cmd_syntax_err_i | cmd_semantic_err_i
                              | trig_in_msg_i;
    evt_set[`SES_BIT_EXE]   = data_range_err_i
                              | exec_fail_i;
    evt_set[`SES_BIT_DDE]   = dev_err_i;
    evt_set[`SES_BIT_QYE]   = query_empty_i
                              | query_lost_i;
    evt_set[`SES_BIT_RQC]   = req_ctrl_i;
    evt_set[`SES_BIT_OPC]   = opc_armed_i & ops_done_i;
    evt_set[`SES_BIT_URQ]   = 1'b0;
  end

  // read and clear command both empty the latch; new events same cycle survive
  assign clr = esr_query_i | cls_i;

  // power-on bit comes from the latch's first cycle after release
  ses_latch #(
    .W (`SES_EVT_W)
  ) u_latch (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rst_val_i (`SES_RST_EVT),
    .set_i     (evt_set),
    .clr_i     (clr),
    .q_o       (evt_q)
  );

  // ****************************************
  // response, mask and summary
  // ****************************************
  logic              resp_valid_r;
  logic              resp_valid_nxt;
  logic [`SES_W-1:0] resp_data_r;
  logic [`SES_W-1:0] resp_data_nxt;
  logic [7:0]        mask_r;
  logic [7:0]        mask_nxt;
  logic              sum_r;
  logic              sum_nxt;

  always_comb begin
    resp_valid_nxt = esr_query_i;
    resp_data_nxt  = resp_data_r;
    if (esr_query_i) begin
      resp_data_nxt = {`SES_RSVD_HI, evt_q};
    end
    // mask resets to all disabled; only an explicit write arms the summary
    mask_nxt = ese_wr_i ? ese_data_i : mask_r;
    // registered so the summary pin has no gate path from the event inputs
    sum_nxt  = |(evt_q & mask_r);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_valid_r <= 1'b0;
      resp_data_r  <= `SES_RST_RESP;
      mask_r       <= `SES_RST_MASK;
      sum_r        <= 1'b0;
    end else begin
      resp_valid_r <= resp_valid_nxt;
      resp_data_r  <= resp_data_nxt;
      mask_r       <= mask_nxt;
      sum_r        <= sum_nxt;
    end
  end

  assign resp_valid_o = resp_valid_r;
  assign resp_data_o  = resp_data_r;
  assign ese_mask_o   = mask_r;
  assign summary_o    = sum_r;

  // ****************************************
  // checks
  // ****************************************
  AST_RESERVED_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    resp_data_o[15:8] == 8'h00) else $error("reserved bits not zero");
  AST_URQ_NEVER: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !evt_q[`SES_BIT_URQ]) else $error("user request bit set");
  AST_CME_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cmd_syntax_err_i | cmd_semantic_err_i) |=> evt_q[`SES_BIT_CME])
    else $error("command error not latched");
  AST_GET_CME: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trig_in_msg_i |=> evt_q[`SES_BIT_CME]) else $error("trigger error not latched");
  AST_EXE_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (data_range_err_i | exec_fail_i) |=> evt_q[`SES_BIT_EXE])
    else $error("execution error not latched");
  AST_DDE_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    dev_err_i |=> evt_q[`SES_BIT_DDE]) else $error("device error not latched");
  AST_QYE_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (query_empty_i | query_lost_i) |=> evt_q[`SES_BIT_QYE])
    else $error("query error not latched");
  AST_OPC_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(evt_q[`SES_BIT_OPC]) |-> $past(opc_armed_i & ops_done_i))
    else $error("opc set without command");
  AST_QUERY_DATA: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    esr_query_i |=> resp_valid_o && resp_data_o[7:0] == $past(evt_q))
    else $error("query answer wrong");
  // power-on merge lands on the first edge after release, so that edge is exempt
  AST_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && (esr_query_i | cls_i) && evt_set == 8'h00 |=> evt_q == 8'h00)
    else $error("register not cleared");
  AST_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(esr_query_i | cls_i) |=> (evt_q & $past(evt_q)) == $past(evt_q))
    else $error("bit dropped without clear");
  AST_SUMMARY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ##1 summary_o == |($past(evt_q) & $past(mask_r))) else $error("summary wrong");
  AST_PON: assert property (@(posedge ref_clk_i)
    $rose(rst_n_i) |=> evt_q[`SES_BIT_PON]) else $error("power on bit missing");

  // ****************************************
  // checks: single event sources, clear command and spurious bits
  // ****************************************
  AST_EXE_FAIL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    exec_fail_i |=> evt_q[`SES_BIT_EXE])
    else $error("internal execution failure not latched");
  AST_QYE_LOST: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    query_lost_i |=> evt_q[`SES_BIT_QYE])
    else $error("lost output data not latched");
  AST_RQC_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_ctrl_i |=> evt_q[`SES_BIT_RQC])
    else $error("control request not latched");
  AST_OPC_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    opc_armed_i && ops_done_i |=> evt_q[`SES_BIT_OPC])
    else $error("operation complete not latched");
  AST_CLS_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && cls_i && evt_set == 8'h00 |=> evt_q == 8'h00)
    else $error("clear command left bits set");
  // no bit appears without an event; bit 7 shows two edges after release, so skip those
  AST_NO_SPUR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $past(rst_n_i, 2) |-> (evt_q & ~$past(evt_q) & ~$past(evt_set)) == 8'h00)
    else $error("bit set without event");

  // ****************************************
  // checks: answer and mask
  // ****************************************
  AST_RESP_PULSE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !esr_query_i |=> !resp_valid_o)
    else $error("answer valid without query");
  // the answer byte must survive until the next query reads the register
  AST_RESP_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !esr_query_i |=> $stable(resp_data_o))
    else $error("answer data moved without query");
  AST_MASK_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ese_wr_i |=> ese_mask_o == $past(ese_data_i))
    else $error("enable mask not written");
  AST_MASK_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !ese_wr_i |=> $stable(ese_mask_o))
    else $error("enable mask moved without write");
  AST_SUM_MASKED: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ese_mask_o == 8'h00 |=> !summary_o)
    else $error("summary set with empty mask");

  COV_QUERY: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    esr_query_i && evt_q != 8'h00);
  COV_SET_CLR: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cls_i && evt_set != 8'h00);
  COV_SUMMARY: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) $rose(summary_o));
  COV_MASK_WRITE: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ese_wr_i && ese_data_i != 8'h00);
  COV_PON_READ: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    esr_query_i && evt_q[`SES_BIT_PON]);
endmodule
`default_nettype wire

// >>> design/ses_map.svh
`ifndef SES_MAP_SVH
`define SES_MAP_SVH
`define SES_W          16
`define SES_EVT_W      8
`define SES_BIT_OPC    0
`define SES_BIT_RQC    1
`define SES_BIT_QYE    2
`define SES_BIT_DDE    3
`define SES_BIT_EXE    4
`define SES_BIT_CME    5
`define SES_BIT_URQ    6
`define SES_BIT_PON    7
`define SES_RST_EVT    8'h80
`define SES_RST_MASK   8'h00
`define SES_ZERO_EVT   8'h00
`define SES_RSVD_HI    8'h00
`define SES_RST_RESP   16'h0000
`endif

// >>> design/ses_pkg.sv
package ses_pkg;
  typedef logic [7:0] evt_t;
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_READ,
    CMD_CLEAR,
    CMD_MASK
  } cmd_e;
endpackage

// >>> design/ses_latch.sv
`timescale 1ns/1ps
`default_nettype none
`include "ses_map.svh"
// sticky bit cell: set wins over clear so no event is lost
module ses_latch
  import ses_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] rst_val_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;
  logic         seeded_r;
  logic         seeded_nxt;

  always_comb begin
    seeded_nxt = 1'b1;
    q_nxt      = (clr_i ? {W{1'b0}} : q_r) | set_i;
    if (!seeded_r) begin
      q_nxt = q_nxt | rst_val_i;
    end
  end

  // reset takes constants; power-on value is merged at release
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r      <= {W{1'b0}};
      seeded_r <= 1'b0;
    end else begin
      q_r      <= q_nxt;
      seeded_r <= seeded_nxt;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

// >>> tb/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// controller side: one-cycle strobes
// ****************************************
module ctrl_model
  import ses_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  // command request
  input  wire cmd_e       cmd_i,
  input  wire logic [7:0] data_i,
  // strobes to the device
  output logic            esr_query_o,
  output logic            cls_o,
  output logic            ese_wr_o,
  output logic      [7:0] ese_data_o
);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      esr_query_o <= 1'b0;
      cls_o       <= 1'b0;
      ese_wr_o    <= 1'b0;
      ese_data_o  <= 8'h00;
    end else begin
      esr_query_o <= (cmd_i == CMD_READ);
      cls_o       <= (cmd_i == CMD_CLEAR);
      ese_wr_o    <= (cmd_i == CMD_MASK);
      // idle data is inverted so a stale byte never looks valid
      ese_data_o  <= (cmd_i == CMD_MASK) ? data_i : ~ese_data_o;
    end
  end
endmodule
`default_nettype wire

// >>> tb/std_event_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module std_event_status_tb
  import ses_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [10:0] evt = 11'h000;
  cmd_e cmd = CMD_NONE;
  logic [7:0] cdat = 8'h00;
  logic q, c, w, rv, sm;
  logic [7:0] wd, mk;
  logic [15:0] rd;
  int fail_count = 0;
  int compares = 0;
  int bitpos [9] = '{5, 5, 5, 4, 4, 3, 2, 2, 1};
  initial forever #25 ref_clk_i = ~ref_clk_i;
  ctrl_model cm (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .data_i(cdat),
    .esr_query_o(q), .cls_o(c), .ese_wr_o(w), .ese_data_o(wd));
  std_event_status dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cmd_syntax_err_i(evt[0]), .cmd_semantic_err_i(evt[1]), .trig_in_msg_i(evt[2]),
    .data_range_err_i(evt[3]), .exec_fail_i(evt[4]), .dev_err_i(evt[5]),
    .query_empty_i(evt[6]), .query_lost_i(evt[7]), .req_ctrl_i(evt[8]),
    .opc_armed_i(evt[9]), .ops_done_i(evt[10]), .esr_query_i(q), .cls_i(c),
    .ese_wr_i(w), .ese_data_i(wd), .resp_valid_o(rv), .resp_data_o(rd),
    .ese_mask_o(mk), .summary_o(sm));
  task automatic finish_test();
    $display("tests done: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  task automatic ev(logic [10:0] v);
    @(posedge ref_clk_i) evt <= v;
    @(posedge ref_clk_i) evt <= 11'h000;
  endtask
  task automatic send(cmd_e k, logic [7:0] d);
    @(posedge ref_clk_i) cmd <= k;
    cdat <= d;
    @(posedge ref_clk_i) cmd <= CMD_NONE;
  endtask
  // answer waits are bounded; a lost answer ends the run
  task automatic query(logic [15:0] exp);
    int i;
    send(CMD_READ, 8'h00);
    for (i = 0; i < 5 && rv !== 1'b1; i++) begin
      @(posedge ref_clk_i) #1;
    end
    if (rv !== 1'b1) begin
      chk("resp_valid_o", 16'h0001, {15'h0000, rv});
      finish_test();
    end
    chk("resp_data_o", exp, rd);
    @(posedge ref_clk_i) #1;
    chk("resp_valid_o", 16'h0000, {15'h0000, rv});
    chk("resp_data_o", exp, rd);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    query(16'h0080);
    query(16'h0000);
    $display("test power_on done");
    for (int k = 0; k < 9; k++) begin
      ev(11'h001 << k);
      query(16'h0001 << bitpos[k]);
    end
    ev(11'h200);
    query(16'h0000);
    ev(11'h600);
    query(16'h0001);
    $display("test events done");
    ev(11'h020);
    ev(11'h010);
    query(16'h0018);
    ev(11'h020);
    send(CMD_CLEAR, 8'h00);
    query(16'h0000);
    ev(11'h010);
    @(posedge ref_clk_i) cmd <= CMD_CLEAR;
    @(posedge ref_clk_i) cmd <= CMD_NONE;
    evt <= 11'h020;
    @(posedge ref_clk_i) evt <= 11'h000;
    query(16'h0008);
    $display("test clear done");
    send(CMD_MASK, 8'h24);
    @(posedge ref_clk_i) #1;
    chk("ese_mask_o", 16'h0024, {8'h00, mk});
    ev(11'h020);
    repeat (2) @(posedge ref_clk_i) #1;
    chk("summary_o", 16'h0000, {15'h0000, sm});
    ev(11'h001);
    repeat (2) @(posedge ref_clk_i) #1;
    chk("summary_o", 16'h0001, {15'h0000, sm});
    query(16'h0028);
    repeat (3) @(posedge ref_clk_i) #1;
    chk("summary_o", 16'h0000, {15'h0000, sm});
    $display("test mask done");
    @(posedge ref_clk_i) rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk("ese_mask_o", 16'h0000, {8'h00, mk});
    query(16'h0080);
    $display("test reset done");
    finish_test();
  end
endmodule
`default_nettype wire
